/* File: rtl/adc_analog_gpio_regs.sv */
// The address map and the Wishbone interface to the registers were left to the implementer.
`timescale 1ns/100ps
module adc_analog_gpio_regs
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // converter analog front end
  input wire logic adc_compare_high,
  output logic adc_sample,
  output logic [9:0] adc_trial,
  // interrupt
  output logic adc_irq,
  // analog tuning words
  output logic [periph_pkg::tuning_count*16-1:0] analog_tuning,
  // general-purpose pins
  input wire logic [periph_pkg::input_count-1:0] gpio_in,
  output logic [periph_pkg::output_count-1:0] gpio_out
);
  typedef struct packed
  {
    logic [periph_pkg::tuning_count*16-1:0] tuning;
    logic [periph_pkg::output_count-1:0] out_drive;
    logic [periph_pkg::input_count-1:0] in_sample;
    logic irq_status;
    logic irq_enable;
    logic irq;
    logic start;
    logic ack;
    logic [31:0] rdata;
    logic sample;
    logic [9:0] trial;
  } bank_type;
  bank_type r;
  bank_type next_r;

  adc_link_if link();

  adc_sequencer sequencer
  (
    .clk(clk),
    .rstn(rstn),
    .link(link)
  );

  assign link.start = r.start;
  assign link.compare_high = adc_compare_high;

  logic access;
  logic [31:0] wmask;
  logic [31:0] tuning_rd;
  logic tuning_hit;

  assign access = wb_cyc_i && wb_stb_i && !r.ack;
  assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  // ==========================================================
  // tuning word decode, one entry per register
  logic [periph_pkg::tuning_count-1:0] tuning_sel;
  logic [periph_pkg::tuning_count*32-1:0] tuning_or;
  genvar g;
  generate
    for (g = 0; g < periph_pkg::tuning_count; g++)
    begin : tune
      assign tuning_sel[g] = (wb_adr_i == 8'(periph_pkg::analog_tuning_word_base + 8'(4 * g)));
      if (g == 0)
        assign tuning_or[31:0] = tuning_sel[0] ? {16'h0000, r.tuning[15:0]} : 32'h0000_0000;
      else
        assign tuning_or[g*32+31:g*32] = tuning_or[g*32-1:g*32-32] |
          (tuning_sel[g] ? {16'h0000, r.tuning[g*16+15:g*16]} : 32'h0000_0000);
    end
  endgenerate
  assign tuning_hit = |tuning_sel;
  assign tuning_rd = tuning_or[periph_pkg::tuning_count*32-1:periph_pkg::tuning_count*32-32];

  // ==========================================================
  // bus access, interrupt and pin capture
  always_comb
  begin
    next_r = r;
    next_r.ack = access;
    next_r.start = 1'b0;
    next_r.rdata = 32'h0000_0000;
    next_r.in_sample = gpio_in;
    next_r.sample = link.sample;
    next_r.trial = link.trial;
    if (access && wb_we_i)
    begin
      for (int i = 0; i < periph_pkg::tuning_count; i++)
      begin
        if (tuning_sel[i])
          next_r.tuning[i*16 +: 16] = (r.tuning[i*16 +: 16] & ~wmask[15:0]) | (wb_dat_i[15:0] & wmask[15:0]);
      end
      case (wb_adr_i)
        periph_pkg::adc_start_offset:
          if (wb_sel_i[0] && wb_dat_i[0] && !link.busy)
            next_r.start = 1'b1;
        periph_pkg::irq_clear_offset:
          if (wb_sel_i[0] && wb_dat_i[0])
            next_r.irq_status = 1'b0;
        periph_pkg::irq_enable_offset:
          if (wb_sel_i[0])
            next_r.irq_enable = wb_dat_i[0];
        periph_pkg::pin_output_drive_offset:
          next_r.out_drive = (r.out_drive & ~wmask[periph_pkg::output_count-1:0]) |
            (wb_dat_i[periph_pkg::output_count-1:0] & wmask[periph_pkg::output_count-1:0]);
        default:
          next_r.out_drive = next_r.out_drive;
      endcase
    end
    if (access && !wb_we_i)
    begin
      case (wb_adr_i)
        periph_pkg::adc_start_offset:
          next_r.rdata = {31'h0000_0000, link.busy || r.start};
        periph_pkg::adc_result_offset:
          next_r.rdata = {22'h00_0000, link.result};
        periph_pkg::irq_status_offset:
          next_r.rdata = {31'h0000_0000, r.irq_status};
        periph_pkg::irq_enable_offset:
          next_r.rdata = {31'h0000_0000, r.irq_enable};
        periph_pkg::pin_input_sample_offset:
          next_r.rdata = 32'(r.in_sample);
        periph_pkg::pin_output_drive_offset:
          next_r.rdata = 32'(r.out_drive);
        default:
          next_r.rdata = tuning_hit ? tuning_rd : 32'h0000_0000;
      endcase
    end
    if (link.done)
      next_r.irq_status = 1'b1;
    next_r.irq = next_r.irq_status && next_r.irq_enable;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      r.tuning <= {periph_pkg::tuning_count{periph_pkg::tuning_reset}};
      r.out_drive <= periph_pkg::output_reset[periph_pkg::output_count-1:0];
      r.in_sample <= '0;
      r.irq_status <= 1'b0;
      r.irq_enable <= periph_pkg::irq_enable_reset;
      r.irq <= 1'b0;
      r.start <= 1'b0;
      r.ack <= 1'b0;
      r.rdata <= 32'h0000_0000;
      r.sample <= 1'b0;
      r.trial <= 10'h000;
    end
    else
      r <= next_r;
  end

  assign wb_dat_o = r.rdata;
  assign wb_ack_o = r.ack;
  assign adc_irq = r.irq;
  assign adc_sample = r.sample;
  assign adc_trial = r.trial;
  assign analog_tuning = r.tuning;
  assign gpio_out = r.out_drive;
endmodule

/* File: rtl/periph_pkg.sv */
// Overview of operation
// - adc controller converts its single analog input to unsigned ten-bit result for software
// - writing one to trigger register starts a self-running conversion sequence
// - trigger register reads one while converting, zero once complete
// - completion raises interrupt request; software may mask and poll instead
// - tuning bank gives parameterised count of sixteen-bit read-write registers
// - tuning writes keep low sixteen bits; reads return upper half zero
// - each tuning register drives its own sixteen-bit field of analog_tuning continuously
// - read-only input register samples up to sixteen pins; writes ignored
// - input register returns n pin values low, zeros above
// - read-write output register drives up to sixteen output pins
// - output writes keep low m bits; reads return them, zeros above
package periph_pkg;
  // ==========================================================
  // register map
  localparam logic [7:0] adc_start_offset = 8'h00;
  localparam logic [7:0] adc_result_offset = 8'h04;
  localparam logic [7:0] irq_status_offset = 8'h08;
  localparam logic [7:0] irq_clear_offset = 8'h0C;
  localparam logic [7:0] irq_enable_offset = 8'h10;
  localparam logic [7:0] pin_input_sample_offset = 8'h14;
  localparam logic [7:0] pin_output_drive_offset = 8'h18;
  localparam logic [7:0] analog_tuning_word_base = 8'h40;
  // ==========================================================
  // sizes and reset values
  localparam int tuning_count = 8;
  localparam int input_count = 16;
  localparam int output_count = 16;
  localparam int result_width = 10;
  localparam logic [15:0] tuning_reset = 16'h0000;
  localparam logic [15:0] output_reset = 16'h0000;
  localparam logic irq_enable_reset = 1'b1;
  // ==========================================================
  // conversion timing: settle then successive approximation
  localparam int clock_mhz = 50;
  localparam int settle_ns = 1000;
  localparam int settle_cycles = (settle_ns * clock_mhz + 999) / 1000;
  localparam int bit_cycles = 4;
  typedef enum logic [3:0]
  {
    adc_idle = 4'b0001,
    adc_settle = 4'b0010,
    adc_convert = 4'b0100,
    adc_done = 4'b1000
  } adc_state_type;
endpackage

/* File: rtl/adc_link_if.sv */
`timescale 1ns/100ps
interface adc_link_if;
  logic start;
  logic busy;
  logic done;
  logic [9:0] result;
  logic sample;
  logic compare_high;
  logic [9:0] trial;
  modport ctrl
  (
    input start,
    output busy,
    output done,
    output result,
    output sample,
    output trial,
    input compare_high
  );
  modport bank
  (
    output start,
    input busy,
    input done,
    input result,
    input sample,
    input trial,
    output compare_high
  );
endinterface

/* File: rtl/adc_sequencer.sv */
`timescale 1ns/100ps
module adc_sequencer
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // link to register bank
  adc_link_if.ctrl link
);
  typedef struct packed
  {
    periph_pkg::adc_state_type state;
    logic [15:0] count;
    logic [3:0] bit_index;
    logic [9:0] trial;
    logic [9:0] result;
    logic done;
    logic sample;
  } seq_type;
  seq_type r;
  seq_type next_r;

  // ==========================================================
  // successive approximation sequence
  always_comb
  begin
    next_r = r;
    next_r.done = 1'b0;
    case (r.state)
      periph_pkg::adc_idle:
      begin
        if (link.start)
        begin
          next_r.state = periph_pkg::adc_settle;
          next_r.count = 16'(periph_pkg::settle_cycles - 1);
          next_r.sample = 1'b1;
        end
      end
      periph_pkg::adc_settle:
      begin
        if (r.count == 16'h0000)
        begin
          next_r.state = periph_pkg::adc_convert;
          next_r.sample = 1'b0;
          next_r.bit_index = 4'h9;
          next_r.trial = 10'h200;
          next_r.count = 16'(periph_pkg::bit_cycles - 1);
        end
        else
          next_r.count = r.count - 16'h0001;
      end
      periph_pkg::adc_convert:
      begin
        if (r.count != 16'h0000)
          next_r.count = r.count - 16'h0001;
        else
        begin
          next_r.count = 16'(periph_pkg::bit_cycles - 1);
          if (!link.compare_high)
            next_r.trial[r.bit_index] = 1'b0;
          if (r.bit_index == 4'h0)
            next_r.state = periph_pkg::adc_done;
          else
          begin
            next_r.bit_index = r.bit_index - 4'h1;
            next_r.trial[r.bit_index - 4'h1] = 1'b1;
          end
        end
      end
      periph_pkg::adc_done:
      begin
        next_r.result = r.trial;
        next_r.done = 1'b1;
        next_r.state = periph_pkg::adc_idle;
      end
      default:
        next_r.state = periph_pkg::adc_idle;
    endcase
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      r <= '{periph_pkg::adc_idle, 16'h0000, 4'h0, 10'h000, 10'h000, 1'b0, 1'b0};
    else
      r <= next_r;
  end

  assign link.busy = (r.state != periph_pkg::adc_idle);
  assign link.done = r.done;
  assign link.result = r.result;
  assign link.sample = r.sample;
  assign link.trial = r.trial;
endmodule

/* File: test/analog_input_model.sv */
`timescale 1ns/100ps
module analog_input_model
(
  // analog level seen by the converter
  input wire logic [9:0] level,
  // comparator
  input wire logic [9:0] adc_trial,
  output logic adc_compare_high
);
  // level sits half a step above its code
  assign adc_compare_high = level >= adc_trial;
endmodule

/* File: test/adc_analog_gpio_regs_properties.sv */
`timescale 1ns/100ps
module adc_analog_gpio_regs_properties
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // wishbone
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // outputs
  input wire logic adc_irq,
  input wire logic [periph_pkg::tuning_count*16-1:0] analog_tuning,
  input wire logic [periph_pkg::output_count-1:0] gpio_out
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rstn);
  wire rd = wb_ack_o && !wb_we_i;
  wire wr = wb_ack_o && wb_we_i && wb_sel_i == 4'hF;
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  ack_latency_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
  irq_mask_a: assert property (wb_ack_o && wb_we_i && wb_adr_i == 8'h10 && wb_sel_i[0] && !wb_dat_i[0]
    |-> ##2 !adc_irq) else $error("masked irq high");
  tuning_out_a: assert property (wr && wb_adr_i == 8'h40
    |=> analog_tuning[15:0] == $past(wb_dat_i[15:0])) else $error("tuning port wrong");
  gpio_write_a: assert property (wr && wb_adr_i == 8'h18
    |=> gpio_out == $past(wb_dat_i[15:0])) else $error("gpio out wrong");
  result_upper_a: assert property (rd && wb_adr_i == 8'h04 |-> wb_dat_o[31:10] == 22'h0) else $error("result");
  tuning_upper_a: assert property (rd && wb_adr_i[7:6] == 2'h1 |-> wb_dat_o[31:16] == 16'h0) else $error("tune");
  input_upper_a: assert property (rd && wb_adr_i == 8'h14 |-> wb_dat_o[31:16] == 16'h0) else $error("input");
  unmapped_read_a: assert property (rd && wb_adr_i == 8'h30 |-> wb_dat_o == 32'h0) else $error("unmapped");
endmodule
bind adc_analog_gpio_regs adc_analog_gpio_regs_properties chk
(
  .clk, .rstn, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
  .wb_dat_i, .wb_dat_o, .wb_ack_o, .adc_irq, .analog_tuning, .gpio_out
);

/* File: test/tb_adc_analog_gpio_regs.sv */
`timescale 1ns/100ps
module tb_adc_analog_gpio_regs;
  logic clk, rstn, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic adc_compare_high, adc_sample, adc_irq;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i, s;
  logic [31:0] wb_dat_i, wb_dat_o, q, d, gout;
  logic [9:0] adc_trial, level;
  logic [periph_pkg::tuning_count*16-1:0] analog_tuning;
  logic [15:0] gpio_in, gpio_out;
  int err_total, checks, n;
  integer seed;
  logic [31:0] tun [8];
  adc_analog_gpio_regs uut
  (
    .clk, .rstn, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
    .wb_ack_o, .adc_compare_high, .adc_sample, .adc_trial, .adc_irq, .analog_tuning, .gpio_in, .gpio_out
  );
  analog_input_model am
  (
    .level, .adc_trial, .adc_compare_high
  );
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // ====
  // reporting and bus cycles
  task automatic complete_run;
    $display("mismatches %0d compares %0d", err_total, checks);
    if (err_total == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e)
    begin
      err_total++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] dd, input logic [3:0] ss);
    int k;
    k = 0;
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= dd;
    wb_sel_i <= ss;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (wb_ack_o !== 1'b1 && k < 20);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (wb_ack_o !== 1'b1)
    begin
      err_total++;
      complete_run();
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(a, 1'b0, 32'h0, 4'hF);
    cmp(q, e);
  endtask
  // ====
  // main sequence
  initial
  begin
    seed = 39;
    err_total = 0;
    checks = 0;
    rstn = 1'b0;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
    gpio_in = 16'h0;
    level = 10'h0;
    gout = 32'h0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    rd(8'h10, 32'h1);
    rd(8'h18, 32'h0);
    for (int i = 0; i < 8; i++)
    begin
      tun[i] = $random(seed);
      rd(8'h40 + 8'(4 * i), 32'h0);
      bus(8'h40 + 8'(4 * i), 1'b1, tun[i], 4'hF);
      rd(8'h40 + 8'(4 * i), tun[i] & 32'hFFFF);
      cmp(analog_tuning[16 * i +: 16], tun[i] & 32'hFFFF);
    end
    for (int i = 0; i < 6; i++)
    begin
      d = $random(seed);
      s = (i == 0) ? 4'hF : 4'($random(seed));
      bus(8'h18, 1'b1, d, s);
      for (int b = 0; b < 2; b++)
        if (s[b]) gout[8 * b +: 8] = d[8 * b +: 8];
      rd(8'h18, gout);
      cmp(gpio_out, gout);
      gpio_in <= 16'($random(seed));
      bus(8'h14, 1'b1, 32'hFFFFFFFF, 4'hF);
      rd(8'h14, gpio_in);
      bus(8'h30, 1'b1, d, 4'hF);
      rd(8'h30, 32'h0);
    end
    for (int r = 0; r < 2; r++)
    begin
      level <= 10'($random(seed));
      bus(8'h10, 1'b1, 32'(1 - r), 4'h1);
      bus(8'h00, 1'b1, 32'h1, 4'h1);
      rd(8'h00, 32'h1);
      cmp(adc_sample, 32'h1);
      bus(8'h00, 1'b1, 32'h1, 4'h1);
      n = 0;
      do
      begin
        bus(8'h00, 1'b0, 32'h0, 4'hF);
        n++;
      end
      while (q[0] === 1'b1 && n < 100);
      cmp(q, 32'h0);
      if (q !== 32'h0)
        complete_run();
      repeat (2) @(posedge clk);
      cmp(adc_irq, 32'(1 - r));
      cmp(adc_sample, 32'h0);
      rd(8'h04, level);
      rd(8'h08, 32'h1);
      if (r == 1)
      begin
        bus(8'h10, 1'b1, 32'h1, 4'h1);
        repeat (2) @(posedge clk);
        cmp(adc_irq, 32'h1);
      end
      bus(8'h0C, 1'b1, 32'h1, 4'h1);
      rd(8'h08, 32'h0);
      cmp(adc_irq, 32'h0);
    end
    complete_run();
  end
endmodule
